//--- chgi_i2c_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [R1] slave only, answers write address D6h
// [R2] runs at 100 and 400 kbit/s
// [R3] open-drain lines, pull low or release only
// [R4] data stable while clock high
// [R5] detect start and stop anytime
// [R6] busy from start until stop
// [R7] eight bits msb first, then ack
// [R8] slave may stretch clock low
// [R9] master makes every clock pulse
// [R10] receiver pulls data low for ack
// [R11] nack then master stops or restarts
// [R12] first byte: address plus direction bit
// [R13] single write: addr, reg, data, acks
// [R14] undefined register address gets nack, idle
// [R15] multi-byte reads and writes supported
// [R16] host writes low byte then high byte
// [R17] paired low byte held, committed together
// [R18] high byte without low byte ignored
// [R19] pair split by watchdog timeout discarded
// [R20] watchdog 175 s, option field, kicked, 00 off
// [R21] charge current 7 bits, 64 mA step
// [R22] voltage limit 12 bits, cell-count default
// [R23] register address advances per data byte
// [R24] single read via repeated start
module chgi_i2c_regs #(
  parameter longint WD_CYCLES = chgi_pkg::WD_175_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // serial bus, open drain
  input wire logic SCL_IN,
  output logic SCL_OE_N,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // cell count strap, 0..3 for one to four cells
  input wire logic [1:0] CELL_COUNT,
  // working settings
  output logic [15:0] CHARGE_CONFIG_A,
  output logic [15:0] CHARGE_CURRENT,
  output logic [15:0] CHARGE_VOLTAGE_LIMIT,
  output logic [15:0] CHARGE_CONFIG_B,
  output logic [15:0] CHARGE_CONFIG_C,
  output logic [15:0] CHARGE_CONFIG_D,
  output logic WATCHDOG_EXPIRED,
  output logic BUS_BUSY
);
  typedef struct packed {
    chgi_pkg::chgi_pins_t pin_d;
    chgi_pkg::chgi_state_t state;
    logic [3:0] bitn;
    logic [7:0] shf;
    logic [7:0] ptr;
    logic have_ptr;
    logic rnw;
    logic nack;
    logic sda_low;
    logic is_data;
    logic busy;
    logic [7:0] pend_lo;
    logic [7:0] pend_ofs;
    logic pend_vld;
    logic [31:0] wd_cnt;
    logic wd_exp;
    logic strap_done;
    logic [15:0] cfg_a;
    logic [15:0] cur;
    logic [15:0] vlim;
    logic [15:0] cfg_b;
    logic [15:0] cfg_c;
    logic [15:0] cfg_d;
  } chgi_st_t;

  chgi_st_t st_reg;
  chgi_st_t st_next;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic defined;
  logic [7:0] rd_byte;
  logic wq_valid;
  logic wq_ready;
  chgi_pkg::chgi_wr_t wq_in;
  logic wr_pop_valid;
  chgi_pkg::chgi_wr_t wr_pop;
  logic [1:0] wd_sel;
  logic [31:0] wd_limit;

  // ************************************************************
  // bus condition decode
  // ************************************************************
  // inputs are already synchronous; one stage of history gives the edges
  assign scl_rise = SCL_IN & ~st_reg.pin_d.scl;
  assign scl_fall = ~SCL_IN & st_reg.pin_d.scl;
  assign start_c = SCL_IN & st_reg.pin_d.scl & st_reg.pin_d.sda & ~SDA_IN; // [R5]
  assign stop_c = SCL_IN & st_reg.pin_d.scl & ~st_reg.pin_d.sda & SDA_IN; // [R5]

  // register address decode and read mux
  always_comb
  begin
    defined = 1'b1;
    rd_byte = 8'h00;
    case (st_reg.ptr)
      chgi_pkg::OFS_CFG_A_LO: rd_byte = st_reg.cfg_a[7:0];
      chgi_pkg::OFS_CFG_A_HI: rd_byte = st_reg.cfg_a[15:8];
      chgi_pkg::OFS_CUR_LO: rd_byte = st_reg.cur[7:0];
      chgi_pkg::OFS_CUR_HI: rd_byte = st_reg.cur[15:8];
      chgi_pkg::OFS_VLIM_LO: rd_byte = st_reg.vlim[7:0];
      chgi_pkg::OFS_VLIM_HI: rd_byte = st_reg.vlim[15:8];
      chgi_pkg::OFS_CFG_B_LO: rd_byte = st_reg.cfg_b[7:0];
      chgi_pkg::OFS_CFG_B_HI: rd_byte = st_reg.cfg_b[15:8];
      chgi_pkg::OFS_CFG_C_LO: rd_byte = st_reg.cfg_c[7:0];
      chgi_pkg::OFS_CFG_C_HI: rd_byte = st_reg.cfg_c[15:8];
      chgi_pkg::OFS_CFG_D_LO: rd_byte = st_reg.cfg_d[7:0];
      chgi_pkg::OFS_CFG_D_HI: rd_byte = st_reg.cfg_d[15:8];
      default: defined = 1'b0;
    endcase
  end

  // ************************************************************
  // write queue between serial side and register file
  // ************************************************************
  // a full queue stretches the clock, so no byte is ever lost
  chgi_fifo #(.WIDTH(16), .DEPTH(4)) u_wq (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(wq_valid),
    .in_ready(wq_ready),
    .in_data(wq_in),
    .out_valid(wr_pop_valid),
    .out_ready(1'b1),
    .out_data(wr_pop)
  );

  assign wd_sel = st_reg.cfg_a[8 + chgi_pkg::WD_SEL_LSB +: 2];
  // lower option codes scale the base timeout down; 11 keeps the full figure
  assign wd_limit = 32'(WD_CYCLES >> (2'd3 - wd_sel));

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.pin_d.scl = SCL_IN;
    st_next.pin_d.sda = SDA_IN;
    wq_valid = 1'b0;
    wq_in.addr = st_reg.ptr;
    wq_in.data = st_reg.shf;
    // strap sampled once after reset release
    if (!st_reg.strap_done)
    begin
      st_next.strap_done = 1'b1;
      case (CELL_COUNT)
        2'd0: st_next.vlim = chgi_pkg::VLIM_1S; // [R22]
        2'd1: st_next.vlim = chgi_pkg::VLIM_2S;
        2'd2: st_next.vlim = chgi_pkg::VLIM_3S;
        default: st_next.vlim = chgi_pkg::VLIM_4S;
      endcase
    end
    // serial engine; master provides every clock edge [R9]
    case (st_reg.state)
      chgi_pkg::ST_ADDR, chgi_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          st_next.shf = {st_reg.shf[6:0], SDA_IN}; // [R4] [R7]
          st_next.bitn = st_reg.bitn + 4'd1;
        end
        if (scl_fall && st_reg.bitn == 4'd8)
        begin
          st_next.bitn = 4'd0;
          st_next.state = chgi_pkg::ST_ACK;
          st_next.is_data = (st_reg.state == chgi_pkg::ST_RX) && st_reg.have_ptr;
          if (st_reg.state == chgi_pkg::ST_ADDR)
          begin
            st_next.nack = (st_reg.shf[7:1] != chgi_pkg::DEV_ADDR); // [R1] [R12]
            st_next.rnw = st_reg.shf[0];
          end
          else if (!st_reg.have_ptr)
          begin
            st_next.ptr = st_reg.shf;
            st_next.have_ptr = 1'b1;
            st_next.nack = 1'b0;
          end
          else
            st_next.nack = ~defined;
          st_next.sda_low = ~st_next.nack; // [R10]
        end
      end
      chgi_pkg::ST_ACK:
      begin
        // pointer byte is checked once latched
        if (st_reg.have_ptr && st_reg.bitn == 4'd0 && !defined && !st_reg.nack)
        begin
          st_next.nack = 1'b1;
          st_next.sda_low = 1'b0; // [R14]
        end
        if (scl_rise)
          st_next.bitn = 4'd1;
        if (scl_fall && st_reg.bitn == 4'd1)
        begin
          st_next.bitn = 4'd0;
          st_next.sda_low = 1'b0;
          if (st_reg.nack)
            st_next.state = chgi_pkg::ST_IDLE; // [R14]
          else if (st_reg.rnw)
          begin
            st_next.state = chgi_pkg::ST_TX;
            st_next.shf = rd_byte;
            st_next.sda_low = ~rd_byte[7];
          end
          else
            st_next.state = chgi_pkg::ST_RX;
        end
      end
      chgi_pkg::ST_TX:
      begin
        if (scl_rise)
          st_next.bitn = st_reg.bitn + 4'd1;
        if (scl_fall)
        begin
          if (st_reg.bitn == 4'd8)
          begin
            st_next.bitn = 4'd0;
            st_next.sda_low = 1'b0; // [R10]
            st_next.state = chgi_pkg::ST_TXACK;
            st_next.ptr = st_reg.ptr + 8'd1; // [R23]
          end
          else
          begin
            st_next.shf = {st_reg.shf[6:0], 1'b0};
            st_next.sda_low = ~st_reg.shf[6];
          end
        end
      end
      chgi_pkg::ST_TXACK:
      begin
        if (scl_rise)
        begin
          st_next.nack = SDA_IN; // [R11] [R24]
          st_next.bitn = 4'd1;
        end
        if (scl_fall && st_reg.bitn == 4'd1)
        begin
          st_next.bitn = 4'd0;
          if (st_reg.nack || !defined)
            st_next.state = chgi_pkg::ST_IDLE;
          else
          begin
            st_next.state = chgi_pkg::ST_TX; // [R15]
            st_next.shf = rd_byte;
            st_next.sda_low = ~rd_byte[7];
          end
        end
      end
      default:;
    endcase
    // data byte accepted: queue it and advance the pointer
    if (st_reg.state == chgi_pkg::ST_ACK && st_reg.have_ptr && !st_reg.rnw
        && !st_reg.nack && scl_fall && st_reg.bitn == 4'd1 && st_reg.is_data)
    begin
      wq_valid = 1'b1; // [R13] [R15]
      st_next.ptr = st_reg.ptr + 8'd1; // [R23]
    end
    if (start_c)
    begin
      st_next.state = chgi_pkg::ST_ADDR; // [R5] [R6]
      st_next.busy = 1'b1;
      st_next.bitn = 4'd0;
      st_next.sda_low = 1'b0;
      st_next.have_ptr = st_reg.have_ptr & st_reg.busy; // repeated start keeps pointer
      st_next.nack = 1'b0;
    end
    if (stop_c)
    begin
      st_next.state = chgi_pkg::ST_IDLE; // [R6]
      st_next.busy = 1'b0;
      st_next.have_ptr = 1'b0;
      st_next.sda_low = 1'b0;
    end
    // ************************************************************
    // register file and paired commit
    // ************************************************************
    if (wd_sel == chgi_pkg::WD_OFF)
    begin
      st_next.wd_cnt = '0;
      st_next.wd_exp = 1'b0; // [R20]
    end
    else if (!st_reg.wd_exp)
    begin
      if (st_reg.wd_cnt >= wd_limit)
      begin
        st_next.wd_exp = 1'b1;
        st_next.cur = chgi_pkg::ZERO16;
        st_next.pend_vld = 1'b0; // [R19]
      end
      else
        st_next.wd_cnt = st_reg.wd_cnt + 32'd1;
    end
    if (wr_pop_valid)
    begin
      // any write other than the matching high byte drops a pending low byte
      st_next.pend_vld = 1'b0; // [R16]
      case (wr_pop.addr)
        chgi_pkg::OFS_CFG_A_LO: st_next.cfg_a[7:0] = wr_pop.data;
        chgi_pkg::OFS_CFG_A_HI: st_next.cfg_a[15:8] = wr_pop.data;
        chgi_pkg::OFS_CFG_B_LO: st_next.cfg_b[7:0] = wr_pop.data;
        chgi_pkg::OFS_CFG_B_HI: st_next.cfg_b[15:8] = wr_pop.data;
        chgi_pkg::OFS_CFG_C_LO: st_next.cfg_c[7:0] = wr_pop.data;
        chgi_pkg::OFS_CFG_C_HI: st_next.cfg_c[15:8] = wr_pop.data;
        chgi_pkg::OFS_CFG_D_LO: st_next.cfg_d[7:0] = wr_pop.data;
        chgi_pkg::OFS_CFG_D_HI: st_next.cfg_d[15:8] = wr_pop.data;
        chgi_pkg::OFS_CUR_LO, chgi_pkg::OFS_VLIM_LO:
        begin
          st_next.pend_lo = wr_pop.data; // [R17]
          st_next.pend_ofs = wr_pop.addr;
          st_next.pend_vld = 1'b1;
        end
        chgi_pkg::OFS_CUR_HI, chgi_pkg::OFS_VLIM_HI:
        begin
          // only a high byte right after its own low byte commits [R18]
          // a fresh pair revives an expired watchdog; one landing as it fires is dropped
          if (st_reg.pend_vld && st_reg.pend_ofs == wr_pop.addr - 8'd1
              && (st_reg.wd_exp || !st_next.wd_exp))
          begin
            if (wr_pop.addr == chgi_pkg::OFS_CUR_HI)
              st_next.cur = {wr_pop.data, st_reg.pend_lo} & chgi_pkg::CUR_MASK; // [R21]
            else
              st_next.vlim = {wr_pop.data, st_reg.pend_lo} & chgi_pkg::VLIM_MASK; // [R22]
            st_next.wd_cnt = '0; // [R20]
            st_next.wd_exp = 1'b0;
          end
        end
        default:;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_reg <= '0;
      st_reg.pin_d <= 2'b11;
      st_reg.cfg_a <= chgi_pkg::CFG_A_RST;
      st_reg.vlim <= chgi_pkg::VLIM_1S;
    end
    else
      st_reg <= st_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SDA_OUT = 1'b0; // [R3]
  assign SDA_OE_N = ~st_reg.sda_low; // [R3]
  assign SCL_OE_N = ~(st_reg.state == chgi_pkg::ST_ACK && ~wq_ready && ~SCL_IN); // [R8] [R2]
  assign CHARGE_CONFIG_A = st_reg.cfg_a;
  assign CHARGE_CURRENT = st_reg.cur;
  assign CHARGE_VOLTAGE_LIMIT = st_reg.vlim;
  assign CHARGE_CONFIG_B = st_reg.cfg_b;
  assign CHARGE_CONFIG_C = st_reg.cfg_c;
  assign CHARGE_CONFIG_D = st_reg.cfg_d;
  assign WATCHDOG_EXPIRED = st_reg.wd_exp;
  assign BUS_BUSY = st_reg.busy;
endmodule : chgi_i2c_regs
`default_nettype wire

//--- chgi_pkg.sv
package chgi_pkg;

  // ************************************************************
  // bus address and register offsets
  // ************************************************************
  localparam logic [6:0] DEV_ADDR = 7'h6B;            // 8-bit write form D6h
  localparam logic [7:0] OFS_CFG_A_LO = 8'h00;
  localparam logic [7:0] OFS_CFG_A_HI = 8'h01;
  localparam logic [7:0] OFS_CUR_LO = 8'h02;
  localparam logic [7:0] OFS_CUR_HI = 8'h03;
  localparam logic [7:0] OFS_VLIM_LO = 8'h04;
  localparam logic [7:0] OFS_VLIM_HI = 8'h05;
  localparam logic [7:0] OFS_CFG_B_LO = 8'h30;
  localparam logic [7:0] OFS_CFG_B_HI = 8'h31;
  localparam logic [7:0] OFS_CFG_C_LO = 8'h32;
  localparam logic [7:0] OFS_CFG_C_HI = 8'h33;
  localparam logic [7:0] OFS_CFG_D_LO = 8'h34;
  localparam logic [7:0] OFS_CFG_D_HI = 8'h35;

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  localparam int WD_SEL_LSB = 5;                      // watchdog option in cfg_a high byte
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [15:0] CUR_MASK = 16'h1FC0;        // 7-bit field, 64 mA step
  localparam logic [15:0] VLIM_MASK = 16'h7FF8;       // 12-bit field, 8 mV step
  localparam logic [15:0] CFG_A_RST = 16'h6000;       // watchdog at 175 s option
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] VLIM_1S = 16'h1068;
  localparam logic [15:0] VLIM_2S = 16'h20D0;
  localparam logic [15:0] VLIM_3S = 16'h3138;
  localparam logic [15:0] VLIM_4S = 16'h41A0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLK_HZ = 20_000_000;
  localparam longint WD_175_S = 175;
  localparam longint WD_175_CYC = WD_175_S * CLK_HZ;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b011,
    ST_ACK = 3'b100,
    ST_TXACK = 3'b101
  } chgi_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } chgi_pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
  } chgi_wr_t;

endpackage : chgi_pkg

//--- chgi_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module chgi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } chgi_fifo_st_t;

  chgi_fifo_st_t st_reg;
  chgi_fifo_st_t st_next;
  logic push;
  logic pop;

  // ************************************************************
  // handshakes
  // ************************************************************
  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // next state
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop)
      st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : chgi_fifo
`default_nettype wire

//--- chgi_i2c_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// bus port checker
// ****************************************
module chgi_i2c_regs_properties (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // serial bus
  input wire logic SCL_IN,
  input wire logic SCL_OE_N,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  // settings and status
  input wire logic [15:0] CHARGE_CURRENT,
  input wire logic [15:0] CHARGE_VOLTAGE_LIMIT,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic BUS_BUSY
);
  logic scl_reg;
  logic sda_reg;
  logic start_seen;
  logic stop_seen;
  // last bus levels, so start and stop are found like the device finds them
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= SCL_IN;
      sda_reg <= SDA_IN;
    end
  end
  assign start_seen = scl_reg && SCL_IN && sda_reg && !SDA_IN;
  assign stop_seen = scl_reg && SCL_IN && !sda_reg && SDA_IN;
  default clocking bus_cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  // the slack of a few cycles covers the registered busy flag
  start_busy_a: assert property (start_seen |-> ##[1:4] BUS_BUSY)
    else $error("busy missing after start");
  stop_free_a: assert property (stop_seen |-> ##[1:4] !BUS_BUSY)
    else $error("busy stuck after stop");
  idle_release_a: assert property (!BUS_BUSY && $past(!BUS_BUSY) |-> SDA_OE_N && SCL_OE_N)
    else $error("line pulled on a free bus");
  sda_hold_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_N))
    else $error("data moved while clock high");
  sda_low_a: assert property (SDA_OUT == 1'b0)
    else $error("data driven high");
  cur_field_a: assert property ((CHARGE_CURRENT & 16'hE03F) == 16'h0000)
    else $error("current outside its field");
  vlim_field_a: assert property ((CHARGE_VOLTAGE_LIMIT & 16'h8007) == 16'h0000)
    else $error("voltage outside its field");
  wd_zero_a: assert property (WATCHDOG_EXPIRED && $past(WATCHDOG_EXPIRED) |-> CHARGE_CURRENT == 16'h0000)
    else $error("current kept after expiry");
  // main scenarios reached
  cover property (start_seen);
  cover property ($fell(SDA_OE_N));
  cover property ($rose(WATCHDOG_EXPIRED));
endmodule : chgi_i2c_regs_properties
bind chgi_i2c_regs chgi_i2c_regs_properties i_chgi_i2c_regs_properties (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SCL_OE_N(SCL_OE_N),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .CHARGE_CURRENT(CHARGE_CURRENT), .CHARGE_VOLTAGE_LIMIT(CHARGE_VOLTAGE_LIMIT),
  .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .BUS_BUSY(BUS_BUSY)
);
`default_nettype wire

//--- chgi_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// two-wire bus master model
// ****************************************
module chgi_bus_master (
  // clock
  input wire logic clk,
  // wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // open-drain drives, 1 releases
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF = 25; // 1.25 us high and low gives 400 kbit/s
  int n;
  // both lines released at power up, idle high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int c);
    repeat (c) @(negedge clk);
  endtask : wt
  // release clock, wait out a stretch with a bound
  task automatic rise;
    scl_o = 1'b1;
    for (n = 0; n < 4000 && !scl_in; n++)
      @(negedge clk);
    wt(HALF);
  endtask : rise
  // start or repeated start
  task automatic start;
    wt(12);
    sda_o = 1'b1;
    wt(13);
    rise();
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b0;
  endtask : start
  // stop
  task automatic stop;
    wt(12);
    sda_o = 1'b0;
    wt(13);
    rise();
    sda_o = 1'b1;
    wt(HALF);
  endtask : stop
  // data only moves in mid low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    wt(12);
    sda_o = b;
    wt(13);
    rise();
    r = sda_in;
    scl_o = 1'b0;
  endtask : bit_io
  // byte out msb first, ninth pulse with data released
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send
  // byte in, answered ack or nack
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask : recv
endmodule : chgi_bus_master
`default_nettype wire

//--- test_charger_i2c_slave_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// register port testbench
// ****************************************
module test_charger_i2c_slave_regs;
  localparam longint WD_TB = 30000; // shortened watchdog so expiry fits the run
  localparam int LIMIT = 80000;
  logic clock, sys_rst, scl_m, sda_m, scl_w, sda_w, scl_oe_n, sda_out, sda_oe_n;
  logic wd_exp, busy;
  logic [1:0] cells;
  logic [15:0] cfg_a, cur, vlim, cfg_b, cfg_c, cfg_d;
  int miscompares, checked, cycles, pend, pdat, m[0:63];
  // wired-and with pull-ups: whoever pulls wins
  assign scl_w = scl_m & scl_oe_n;
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  chgi_i2c_regs #(.WD_CYCLES(WD_TB)) i_chgi_i2c_regs (
    .CLOCK(clock), .SYS_RST(sys_rst), .SCL_IN(scl_w), .SCL_OE_N(scl_oe_n),
    .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .CELL_COUNT(cells),
    .CHARGE_CONFIG_A(cfg_a), .CHARGE_CURRENT(cur), .CHARGE_VOLTAGE_LIMIT(vlim),
    .CHARGE_CONFIG_B(cfg_b), .CHARGE_CONFIG_C(cfg_c), .CHARGE_CONFIG_D(cfg_d),
    .WATCHDOG_EXPIRED(wd_exp), .BUS_BUSY(busy)
  );
  chgi_bus_master i_chgi_bus_master (
    .clk(clock), .scl_in(scl_w), .sda_in(sda_w), .scl_o(scl_m), .sda_o(sda_m)
  );
  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [15:0] pair(input int a);
    return 16'((m[a + 1] << 8) | m[a]);
  endfunction : pair
  // model: low byte waits, high byte commits only behind its own low byte
  task automatic put(input int a, input int d);
    if (a == 2 || a == 4)
    begin
      pend = a;
      pdat = d;
    end
    else if (a == 3 || a == 5)
    begin
      if (pend == a - 1)
      begin
        m[a - 1] = pdat;
        m[a] = d;
      end
      pend = -1;
    end
    else
    begin
      m[a] = d;
      pend = -1;
    end
  endtask : put
  task automatic check_regs;
    cmp(cfg_a, pair(0));
    cmp(cur, pair(2) & 16'h1FC0);
    cmp(vlim, pair(4) & 16'h7FF8);
    cmp(cfg_b, pair(8'h30));
    cmp(cfg_c, pair(8'h32));
    cmp(cfg_d, pair(8'h34));
  endtask : check_regs
  // write transfer; data bytes skipped when the register is refused
  task automatic wr(input logic [7:0] r, input logic [7:0] q[$]);
    logic a;
    logic ok;
    i_chgi_bus_master.start();
    i_chgi_bus_master.send({chgi_pkg::DEV_ADDR, 1'b0}, a);
    cmp(16'(a), 16'h0001);
    cmp(16'(busy), 16'h0001);
    ok = r inside {[8'h00:8'h05], [8'h30:8'h35]};
    i_chgi_bus_master.send(r, a);
    cmp(16'(a), 16'(ok));
    for (int i = 0; ok && i < q.size(); i++)
    begin
      i_chgi_bus_master.send(q[i], a);
      cmp(16'(a), 16'h0001);
      put(r + i, q[i]);
    end
    i_chgi_bus_master.stop();
    repeat (8) @(negedge clock);
    cmp(16'(busy), 16'h0000);
    check_regs();
  endtask : wr
  // read through a repeated start, nack on the last byte
  task automatic rd(input logic [7:0] r, input int cnt);
    logic a;
    logic [7:0] d;
    i_chgi_bus_master.start();
    i_chgi_bus_master.send({chgi_pkg::DEV_ADDR, 1'b0}, a);
    i_chgi_bus_master.send(r, a);
    i_chgi_bus_master.start();
    i_chgi_bus_master.send({chgi_pkg::DEV_ADDR, 1'b1}, a);
    cmp(16'(a), 16'h0001);
    for (int i = 0; i < cnt; i++)
    begin
      i_chgi_bus_master.recv(i < cnt - 1, d);
      cmp({8'h00, d}, 16'(m[r + i]));
    end
    i_chgi_bus_master.stop();
  endtask : rd
  // main sequence
  initial
  begin
    int v;
    logic a;
    logic [7:0] q[$];
    void'($urandom(45));
    sys_rst = 1'b1;
    cells = 2'($urandom_range(0, 3));
    pend = -1;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    v = (cells + 1) * 4200;
    m[1] = 8'h60;
    m[4] = v & 255;
    m[5] = v >> 8;
    check_regs();
    $display("test reset values done");
    i_chgi_bus_master.start();
    i_chgi_bus_master.send({chgi_pkg::DEV_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, a);
    cmp(16'(a), 16'h0000);
    i_chgi_bus_master.stop();
    $display("test foreign address done");
    repeat (2) q.push_back(8'($urandom));
    wr(8'h02, q);
    wr(8'h05, '{q[0]});
    $display("test current pair done");
    wr(8'h04, '{q[1]});
    repeat (WD_TB + 1000) @(negedge clock);
    cmp(16'(wd_exp), 16'h0001);
    m[2] = 0;
    m[3] = 0;
    pend = -1;
    wr(8'h05, '{q[0]});
    wr(8'h02, q);
    cmp(16'(wd_exp), 16'h0000);
    $display("test watchdog split done");
    wr(8'h00, '{q[1], q[0] & 8'h9F});
    cmp(16'(wd_exp), 16'h0000);
    wr(8'h04, '{q[0], q[1]});
    $display("test watchdog off done");
    repeat (4) q.push_back(8'($urandom));
    wr(8'h30, q);
    wr(8'h10, q);
    rd(8'h30, 6);
    $display("test multi byte done");
    stop_test();
  end
endmodule : test_charger_i2c_slave_regs
`default_nettype wire
